// File: hdl/ppc_pkg.sv
// constants for the per-port phy control register bank
package ppc_pkg;

    // ports served by this bank; the third switch port has no phy
    localparam int PPC_NPORTS = 2;

    // register port
    localparam int PPC_AW = 8;
    localparam int PPC_DW = 8;

    // per-port address layout: port n sits at PPC_PORT_BASE + (n - 1) * PPC_PORT_STRIDE plus the slot offset
    localparam logic [7:0] PPC_PORT_BASE = 8'h10;
    localparam logic [7:0] PPC_PORT_STRIDE = 8'h10;
    localparam logic [7:0] PPC_OFS_SPECIAL = 8'h0A;
    localparam logic [7:0] PPC_OFS_FAULT_LO = 8'h0B;
    localparam logic [7:0] PPC_OFS_CTRL_A = 8'h0C;
    localparam logic [7:0] PPC_OFS_CTRL_B = 8'h0D;

    // absolute addresses
    localparam logic [7:0] PPC_ADDR_P1_SPECIAL = 8'h1A;
    localparam logic [7:0] PPC_ADDR_P1_FAULT_LO = 8'h1B;
    localparam logic [7:0] PPC_ADDR_P1_CTRL_A = 8'h1C;
    localparam logic [7:0] PPC_ADDR_P1_CTRL_B = 8'h1D;
    localparam logic [7:0] PPC_ADDR_P2_SPECIAL = 8'h2A;
    localparam logic [7:0] PPC_ADDR_P2_FAULT_LO = 8'h2B;
    localparam logic [7:0] PPC_ADDR_P2_CTRL_A = 8'h2C;
    localparam logic [7:0] PPC_ADDR_P2_CTRL_B = 8'h2D;

    // control a fields
    localparam int PPC_A_AN_EN = 7;
    localparam int PPC_A_FORCE_SPD = 6;
    localparam int PPC_A_FORCE_DPX = 5;
    localparam int PPC_A_ADV_PAUSE = 4;
    localparam int PPC_A_ADV_100FD = 3;
    localparam int PPC_A_ADV_100HD = 2;
    localparam int PPC_A_ADV_10FD = 1;
    localparam int PPC_A_ADV_10HD = 0;
    localparam logic [3:0] PPC_A_ADV_RESET = 4'hF;

    // control b fields (bits 2..0 belong to other logic and read zero here)
    localparam int PPC_B_LED_OFF = 7;
    localparam int PPC_B_TX_DIS = 6;
    localparam int PPC_B_RESTART = 5;
    localparam int PPC_B_FEF_DIS = 4;
    localparam int PPC_B_PWR_DOWN = 3;
    localparam int PPC_B_LSB = 3;
    localparam logic [4:0] PPC_B_RESET = 5'h00;

    // special control/status: fault distance msb
    localparam int PPC_S_FAULT_MSB = 0;

    // fault distance
    localparam int PPC_FAULT_W = 9;
    localparam int PPC_FAULT_DM_PER_COUNT = 4;

    // led pins
    localparam int PPC_LED_W = 4;
    localparam logic [3:0] PPC_LED_DARK = 4'hF;

    // strap vector layout
    localparam int PPC_STRAP_W = 7;
    localparam int PPC_STRAP_NEG = 0;
    localparam int PPC_STRAP_SPD = 1;
    localparam int PPC_STRAP_DPX = 2;
    localparam int PPC_STRAP_PER_PORT = 3;
    localparam int PPC_STRAP_PAUSE = 6;

    localparam logic [7:0] PPC_RDATA_RESET = 8'h00;

endpackage

// File: hdl/ppc_phy_port_regs.sv
// per-port phy control and fault-distance registers for the two phy ports
`timescale 1ns/1ns
`default_nettype none

// ************************************************************
// register map and timing
// ************************************************************
// port 1 occupies 0x1A to 0x1D, port 2 the same slots 0x10 higher
// 0x1A/0x2A: bit 0 carries the fault distance msb, other bits read zero
// 0x1B/0x2B: low byte of the fault distance, read-only
// 0x1C/0x2C: negotiation enable, forced speed and duplex, advertised abilities
// 0x1D/0x2D: led-off, transmit-disable, restart, far-end fault off, power down
// writes to read-only, reserved or unmapped slots are dropped silently
// read data appears one cycle after the strobe and holds until the next read
// the two fault bytes are not latched together; read them while the count is stable
// reset must stay low five cycles or more so the strap filter settles first

module ppc_phy_port_regs
    import ppc_pkg::*;
(
    input wire logic mclk, // 10 MHz system clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic [PPC_AW-1:0] reg_addr, // register address
    input wire logic reg_wr, // write strobe, one cycle
    input wire logic [PPC_DW-1:0] reg_wdata, // write data
    input wire logic reg_rd, // read strobe, one cycle
    output logic [PPC_DW-1:0] reg_rdata, // read data, valid the cycle after reg_rd
    input wire logic port1_negotiate_strap, // strap pin
    input wire logic port2_negotiate_strap, // strap pin
    input wire logic port1_speed_strap, // strap pin
    input wire logic port2_speed_strap, // strap pin
    input wire logic port1_duplex_strap, // strap pin
    input wire logic port2_duplex_strap, // strap pin
    input wire logic pause_advertise_strap, // strap pin, shared by both ports
    input wire logic [PPC_FAULT_W-1:0] fault_count_p1, // diagnostic fault distance
    input wire logic [PPC_FAULT_W-1:0] fault_count_p2, // diagnostic fault distance
    input wire logic [1:0] an_speed_100, // negotiated speed per port
    input wire logic [1:0] an_full_duplex, // negotiated duplex per port
    input wire logic [1:0] an_failed, // negotiation failed per port
    input wire logic [PPC_LED_W-1:0] led_in_p1, // led drive from status logic
    input wire logic [PPC_LED_W-1:0] led_in_p2, // led drive from status logic
    output logic [PPC_LED_W-1:0] port_led_out_p1, // led pins port 1
    output logic [PPC_LED_W-1:0] port_led_out_p2, // led pins port 2
    output logic [1:0] negotiate_en, // negotiation enable per port
    output logic [1:0] link_speed_100, // speed in use per port
    output logic [1:0] link_full_duplex, // duplex in use per port
    output logic [4:0] advertise_p1, // pause,100fd,100hd,10fd,10hd
    output logic [4:0] advertise_p2, // pause,100fd,100hd,10fd,10hd
    output logic [1:0] tx_disable, // transmitter off per port
    output logic [1:0] negotiate_restart, // one-cycle restart pulse per port
    output logic far_end_fault_disable, // fiber far-end fault off, port 1
    output logic [1:0] power_down // phy power down per port
);

    // ************************************************************
    // state
    // ************************************************************

    typedef struct packed {
        logic [PPC_STRAP_W-1:0] strap_s1;
        logic [PPC_STRAP_W-1:0] strap_s2;
        logic [PPC_STRAP_W-1:0] strap_s3;
        logic [PPC_STRAP_W-1:0] strap_f;
        logic [1:0][7:0] ctrl_a;
        logic [1:0][4:0] ctrl_b;
        logic [PPC_DW-1:0] rdata;
        logic [1:0] restart;
        logic [1:0][PPC_LED_W-1:0] led;
        logic [1:0] spd;
        logic [1:0] dpx;
    } ppc_state_t;

    ppc_state_t st_reg;
    ppc_state_t st_next;
    logic [PPC_STRAP_W-1:0] strap_pins;
    logic [1:0][PPC_FAULT_W-1:0] fault;
    logic [1:0][PPC_LED_W-1:0] led_in;

    assign strap_pins = {pause_advertise_strap,
                         port2_duplex_strap, port2_speed_strap, port2_negotiate_strap,
                         port1_duplex_strap, port1_speed_strap, port1_negotiate_strap};
    assign fault[0] = fault_count_p1;
    assign fault[1] = fault_count_p2;
    assign led_in[0] = led_in_p1;
    assign led_in[1] = led_in_p2;

    // ************************************************************
    // next state
    // ************************************************************

    always_comb begin
        st_next = st_reg;

        // straps: three flops, a change counts once stages two and three agree
        st_next.strap_s1 = strap_pins;
        st_next.strap_s2 = st_reg.strap_s1;
        st_next.strap_s3 = st_reg.strap_s2;
        for (int b = 0; b < PPC_STRAP_W; b++) begin
            if (st_reg.strap_s2[b] == st_reg.strap_s3[b]) begin
                st_next.strap_f[b] = st_reg.strap_s3[b];
            end
        end

        // restart lasts one cycle; the stored bit stays as written, and each write with the restart bit set re-fires
        st_next.restart = 2'b00;

        // writes reach only the control slots; read-only and reserved slots drop them
        if (reg_wr) begin
            if (reg_addr == PPC_ADDR_P1_CTRL_A) begin
                st_next.ctrl_a[0] = reg_wdata;
            end else if (reg_addr == PPC_ADDR_P1_CTRL_B) begin
                st_next.ctrl_b[0] = reg_wdata[7:PPC_B_LSB];
                st_next.restart[0] = reg_wdata[PPC_B_RESTART];
            end else if (reg_addr == PPC_ADDR_P2_CTRL_A) begin
                st_next.ctrl_a[1] = reg_wdata;
            end else if (reg_addr == PPC_ADDR_P2_CTRL_B) begin
                st_next.ctrl_b[1] = reg_wdata[7:PPC_B_LSB];
                st_next.restart[1] = reg_wdata[PPC_B_RESTART];
            end
        end

        // link selection and led blanking, per port
        for (int p = 0; p < PPC_NPORTS; p++) begin
            if (!st_reg.ctrl_a[p][PPC_A_AN_EN]) begin
                st_next.spd[p] = st_reg.ctrl_a[p][PPC_A_FORCE_SPD];
            end else begin
                st_next.spd[p] = an_speed_100[p];
            end
            if (!st_reg.ctrl_a[p][PPC_A_AN_EN] || an_failed[p]) begin
                st_next.dpx[p] = st_reg.ctrl_a[p][PPC_A_FORCE_DPX];
            end else begin
                st_next.dpx[p] = an_full_duplex[p];
            end

            if (st_reg.ctrl_b[p][PPC_B_LED_OFF - PPC_B_LSB]) begin
                st_next.led[p] = PPC_LED_DARK;
            end else begin
                st_next.led[p] = led_in[p];
            end
        end

        // read decode, port 3 slots and unmapped addresses read zero
        // a read that meets a write in one cycle returns the value before the write
        if (reg_rd) begin
            st_next.rdata = PPC_RDATA_RESET;
            if (reg_addr == PPC_ADDR_P1_SPECIAL) begin
                st_next.rdata[PPC_S_FAULT_MSB] = fault[0][PPC_FAULT_W-1];
            end else if (reg_addr == PPC_ADDR_P1_FAULT_LO) begin
                st_next.rdata = fault[0][7:0];
            end else if (reg_addr == PPC_ADDR_P1_CTRL_A) begin
                st_next.rdata = st_reg.ctrl_a[0];
            end else if (reg_addr == PPC_ADDR_P1_CTRL_B) begin
                st_next.rdata = {st_reg.ctrl_b[0], 3'h0};
            end else if (reg_addr == PPC_ADDR_P2_SPECIAL) begin
                st_next.rdata[PPC_S_FAULT_MSB] = fault[1][PPC_FAULT_W-1];
            end else if (reg_addr == PPC_ADDR_P2_FAULT_LO) begin
                st_next.rdata = fault[1][7:0];
            end else if (reg_addr == PPC_ADDR_P2_CTRL_A) begin
                st_next.rdata = st_reg.ctrl_a[1];
            end else if (reg_addr == PPC_ADDR_P2_CTRL_B) begin
                st_next.rdata = {st_reg.ctrl_b[1], 3'h0};
            end
        end

        // advertise ones; pause follows the shared strap
        // hold reset at least five cycles so the filtered straps settle
        if (!rstn) begin
            // port 1 straps sit in the low three bits of the filtered vector
            st_next.ctrl_a[0] = {st_reg.strap_f[PPC_STRAP_NEG],
                                 st_reg.strap_f[PPC_STRAP_SPD],
                                 st_reg.strap_f[PPC_STRAP_DPX],
                                 st_reg.strap_f[PPC_STRAP_PAUSE],
                                 PPC_A_ADV_RESET};
            // port 2 straps follow one group higher; the pause strap is shared
            st_next.ctrl_a[1] = {st_reg.strap_f[PPC_STRAP_PER_PORT + PPC_STRAP_NEG],
                                 st_reg.strap_f[PPC_STRAP_PER_PORT + PPC_STRAP_SPD],
                                 st_reg.strap_f[PPC_STRAP_PER_PORT + PPC_STRAP_DPX],
                                 st_reg.strap_f[PPC_STRAP_PAUSE],
                                 PPC_A_ADV_RESET};
            st_next.ctrl_b[0] = PPC_B_RESET;
            st_next.ctrl_b[1] = PPC_B_RESET;
            // leds stay dark while the port is held in reset
            st_next.led[0] = PPC_LED_DARK;
            st_next.led[1] = PPC_LED_DARK;
            st_next.rdata = PPC_RDATA_RESET;
            st_next.restart = 2'b00;
            st_next.spd = 2'b00;
            st_next.dpx = 2'b00;
        end
    end

    always_ff @(posedge mclk) begin
        st_reg <= st_next;
    end

    // ************************************************************
    // outputs
    // ************************************************************

    assign reg_rdata = st_reg.rdata;
    assign port_led_out_p1 = st_reg.led[0];
    assign port_led_out_p2 = st_reg.led[1];
    assign link_speed_100 = st_reg.spd;
    assign link_full_duplex = st_reg.dpx;
    assign negotiate_restart = st_reg.restart;
    assign advertise_p1 = st_reg.ctrl_a[0][4:0];
    assign advertise_p2 = st_reg.ctrl_a[1][4:0];

    genvar gp;
    generate
        for (gp = 0; gp < PPC_NPORTS; gp++) begin : g_port
            assign negotiate_en[gp] = st_reg.ctrl_a[gp][PPC_A_AN_EN];
            assign tx_disable[gp] = st_reg.ctrl_b[gp][PPC_B_TX_DIS - PPC_B_LSB];
            assign power_down[gp] = st_reg.ctrl_b[gp][PPC_B_PWR_DOWN - PPC_B_LSB];
        end
    endgenerate

    // fiber only on port 1; port 2's copy is stored but has no effect
    assign far_end_fault_disable = st_reg.ctrl_b[0][PPC_B_FEF_DIS - PPC_B_LSB];

endmodule

`default_nettype wire

// File: verif/ppc_phy_port_regs_props.sv
// port checker for the phy port control register bank
`timescale 1ns/1ns
`default_nettype none
// ****************
// port relations
// ****************
module ppc_phy_port_regs_props
    import ppc_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic rstn, // reset, active low
    input wire logic [PPC_AW-1:0] reg_addr, // address
    input wire logic reg_wr, // write strobe
    input wire logic [PPC_DW-1:0] reg_wdata, // write data
    input wire logic reg_rd, // read strobe
    input wire logic [PPC_DW-1:0] reg_rdata, // read data
    input wire logic [PPC_FAULT_W-1:0] fault_count_p1, // fault distance
    input wire logic [1:0] an_speed_100, // negotiated speed
    input wire logic [PPC_LED_W-1:0] port_led_out_p1, // led pins
    input wire logic [1:0] negotiate_en, // negotiation on
    input wire logic [1:0] link_speed_100, // speed in use
    input wire logic [4:0] advertise_p1, // abilities port 1
    input wire logic [4:0] advertise_p2, // abilities port 2
    input wire logic [1:0] tx_disable, // transmitter off
    input wire logic [1:0] negotiate_restart, // restart pulse
    input wire logic far_end_fault_disable, // fiber fault off
    input wire logic [1:0] power_down // power down
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic wr_b1;
    assign wr_b1 = reg_wr && reg_addr == PPC_ADDR_P1_CTRL_B;

    a_fault_low_read: assert property (reg_rd && reg_addr == PPC_ADDR_P1_FAULT_LO |=>
        reg_rdata == $past(fault_count_p1[7:0])) else $error("fault low read wrong");
    a_fault_msb_read: assert property (reg_rd && reg_addr == PPC_ADDR_P1_SPECIAL |=>
        reg_rdata == {7'h00, $past(fault_count_p1[8])}) else $error("fault msb read wrong");
    a_ctrl_a_read: assert property (reg_rd && reg_addr == PPC_ADDR_P1_CTRL_A |=>
        reg_rdata[7] == $past(negotiate_en[0]) && reg_rdata[4:0] == $past(advertise_p1))
        else $error("control a read wrong");
    a_p2_ctrl_write: assert property (reg_wr && reg_addr == PPC_ADDR_P2_CTRL_A |=>
        advertise_p2 == $past(reg_wdata[4:0]) && negotiate_en[1] == $past(reg_wdata[7]))
        else $error("port 2 control a write not applied");
    a_ctrl_b_write: assert property (wr_b1 |=> tx_disable[0] == $past(reg_wdata[6]) &&
        power_down[0] == $past(reg_wdata[3]) && far_end_fault_disable == $past(reg_wdata[4]))
        else $error("control b write not applied");
    a_restart_pulse: assert property (wr_b1 && reg_wdata[5] |=> negotiate_restart[0])
        else $error("restart pulse missing");
    a_restart_cause: assert property (negotiate_restart[0] |-> $past(wr_b1) &&
        $past(reg_wdata[5])) else $error("restart pulse without write");
    a_led_blank: assert property (wr_b1 && reg_wdata[7] |=> ##1
        port_led_out_p1 == PPC_LED_DARK) else $error("leds not dark");
    a_speed_follow: assert property (negotiate_en[0] && $past(rstn) |=>
        link_speed_100[0] == $past(an_speed_100[0])) else $error("speed not negotiated");
    a_unmapped_read: assert property (reg_rd && reg_addr == 8'h3C |=> reg_rdata == 8'h00)
        else $error("reserved read not zero");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without read");
    c_restart: cover property (negotiate_restart[0]);
    c_leds_dark: cover property (port_led_out_p1 == PPC_LED_DARK ##1 negotiate_en[0]);
    c_p2_write: cover property (reg_wr && reg_addr == PPC_ADDR_P2_CTRL_B);
endmodule

bind ppc_phy_port_regs ppc_phy_port_regs_props ppc_phy_port_regs_props_i (.mclk, .rstn,
    .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .fault_count_p1, .an_speed_100,
    .port_led_out_p1, .negotiate_en, .link_speed_100, .advertise_p1, .advertise_p2,
    .tx_disable, .negotiate_restart, .far_end_fault_disable, .power_down);
`default_nettype wire

// File: verif/tb_ppc_phy_port_regs.sv
// self-checking bench for the phy port control register bank
`timescale 1ns/1ns
`default_nettype none
// ****************
// bench
// ****************
module tb_ppc_phy_port_regs;
    import ppc_pkg::*;
    logic mclk, rstn, reg_wr, reg_rd, pause_advertise_strap, far_end_fault_disable;
    logic port1_negotiate_strap, port2_negotiate_strap, port1_speed_strap, port2_speed_strap;
    logic port1_duplex_strap, port2_duplex_strap;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [8:0] fault_count_p1, fault_count_p2;
    logic [1:0] an_speed_100, an_full_duplex, an_failed, negotiate_en, link_speed_100;
    logic [1:0] link_full_duplex, tx_disable, negotiate_restart, power_down, pulse;
    logic [3:0] led_in_p1, led_in_p2, port_led_out_p1, port_led_out_p2;
    logic [4:0] advertise_p1, advertise_p2;
    int errors = 0;
    int n_compared = 0;

    ppc_phy_port_regs ppc_phy_port_regs_i (.*);

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // each access owns two cycles so a strobe is never set twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge mclk);
        #5 reg_wr = 1'b0;
        pulse = negotiate_restart;
        @(posedge mclk);
        #5;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge mclk);
        #5 reg_rd = 1'b0;
        chk(reg_rdata, exp);
        @(posedge mclk);
        #5;
    endtask

    task automatic complete_run;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        {rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {port1_negotiate_strap, port1_speed_strap, port1_duplex_strap} = 3'b101;
        {port2_negotiate_strap, port2_speed_strap, port2_duplex_strap} = 3'b010;
        pause_advertise_strap = 1'b1;
        fault_count_p1 = 9'h1A5;
        fault_count_p2 = 9'h05A;
        an_speed_100 = 2'b01;
        an_full_duplex = 2'b10;
        an_failed = 2'b00;
        led_in_p1 = 4'h5;
        led_in_p2 = 4'hA;
        repeat (6) @(posedge mclk);
        #5 rstn = 1'b1;
        rd(PPC_ADDR_P1_CTRL_A, 8'hBF);
        rd(PPC_ADDR_P2_CTRL_A, 8'h5F);
        rd(PPC_ADDR_P1_CTRL_B, 8'h00);
        chk({4'h0, port_led_out_p1}, 8'h05);
        rd(PPC_ADDR_P1_FAULT_LO, 8'hA5);
        rd(PPC_ADDR_P1_SPECIAL, 8'h01);
        rd(PPC_ADDR_P2_FAULT_LO, 8'h5A);
        rd(PPC_ADDR_P2_SPECIAL, 8'h00);
        wr(PPC_ADDR_P1_FAULT_LO, 8'hFF);
        rd(PPC_ADDR_P1_FAULT_LO, 8'hA5);
        chk({4'h0, link_speed_100, link_full_duplex}, 8'h0C);
        an_failed = 2'b01;
        @(posedge mclk);
        #5 chk({6'h00, link_full_duplex}, 8'h01);
        wr(PPC_ADDR_P2_CTRL_A, 8'h20);
        chk({4'h0, link_speed_100, link_full_duplex}, 8'h07);
        chk({3'h0, advertise_p2}, 8'h00);
        wr(PPC_ADDR_P1_CTRL_A, 8'h0A);
        chk({3'h0, advertise_p1}, 8'h0A);
        rd(PPC_ADDR_P1_CTRL_A, 8'h0A);
        wr(PPC_ADDR_P1_CTRL_B, 8'hFF);
        chk({6'h00, pulse}, 8'h01);
        rd(PPC_ADDR_P1_CTRL_B, 8'hF8);
        chk({4'h0, port_led_out_p1}, 8'h0F);
        chk({3'h0, far_end_fault_disable, tx_disable, power_down}, 8'h15);
        wr(PPC_ADDR_P2_CTRL_B, 8'h58);
        chk({6'h00, pulse}, 8'h00);
        chk({3'h0, far_end_fault_disable, tx_disable, power_down}, 8'h1F);
        chk({4'h0, port_led_out_p2}, 8'h0A);
        wr(PPC_ADDR_P1_CTRL_B, 8'h00);
        chk({3'h0, far_end_fault_disable, tx_disable, power_down}, 8'h0A);
        chk({4'h0, port_led_out_p1}, 8'h05);
        for (logic [7:0] a = 8'h3A; a < 8'h3E; a++) begin
            wr(a, 8'hFF);
            rd(a, 8'h00);
        end
        complete_run();
    end
endmodule
`default_nettype wire
